//--- rtl/asq_regs.svh
// register offsets, field positions and reset values of the step nine and ten configs
// assumes an 8-bit register address and 16-bit register data
`ifndef ASQ_REGS_SVH
`define ASQ_REGS_SVH
`define ASQ_STEP9_ADDR 8'h99
`define ASQ_STEP10_ADDR 8'h9a
`define ASQ_STEP9_RST 16'h0009
`define ASQ_STEP10_RST 16'h000a
`define ASQ_EN_BIT 15
`define ASQ_GAIN_HI 14
`define ASQ_GAIN_LO 13
`define ASQ_NEG_BIT 4
`define ASQ_POS_HI 3
`define ASQ_POS_LO 0
`define ASQ_RW_MASK 16'he01f
`endif

//--- rtl/asq_pkg.sv
// types shared by the sequencer step configuration block
// assumes the register header is included by its users
package asq_pkg;
  typedef enum logic [1:0] {
    ASQ_GAIN_1 = 2'h0,
    ASQ_GAIN_2 = 2'h1,
    ASQ_GAIN_4 = 2'h2
  } asq_gain_t;

  typedef enum logic [1:0] {
    ASQ_NEG_GND = 2'h0,
    ASQ_NEG_MUX7 = 2'h1,
    ASQ_NEG_AUTO = 2'h2
  } asq_neg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } asq_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] step;
    asq_gain_t gain;
    logic [3:0] pos_sel;
    asq_neg_t neg_sel;
  } asq_conv_t;
endpackage

//--- rtl/asq_step_cfg.sv
// step nine and ten configuration registers of the auxiliary sequencer, with step apply logic
// assumes a serial register front end that hands over decoded read and write strobes
`include "asq_regs.svh"

// Behaviour
// - bit 15 includes step in sequence
// - gain code 00=1, 01=2, 1x=4
// - bit 4 picks ground or input seven
// - positive codes 0-7 route mux inputs
// - positive codes 8-15 pick internal sources
// - internal sources ignore negative select bit
// - step ten at 9Ah, reset 000Ah
// - step nine at 99h, reset 0009h
module asq_step_cfg (
  input wire logic i_clk,
  input wire logic i_resetn,
  input asq_pkg::asq_req_t i_req,
  input wire logic i_step_req,
  input wire logic [3:0] i_step_num,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output asq_pkg::asq_conv_t o_conv,
  output logic o_step_skip
);
  import asq_pkg::*;

  logic [15:0] step9_r;
  logic [15:0] step10_r;
  logic [15:0] rdata_nxt;
  logic [15:0] sel_cfg;
  logic hit9;
  logic hit10;
  logic is_step9;
  logic is_step10;
  logic step_known;
  asq_conv_t conv_nxt;

  function automatic asq_gain_t gain_decode(input logic [1:0] code);
    gain_decode = code[1] ? ASQ_GAIN_4 : (code[0] ? ASQ_GAIN_2 : ASQ_GAIN_1);
  endfunction

  function automatic asq_neg_t neg_decode(input logic [3:0] pos, input logic neg);
    if (pos[3]) begin
      neg_decode = ASQ_NEG_AUTO;
    end else begin
      neg_decode = neg ? ASQ_NEG_MUX7 : ASQ_NEG_GND;
    end
  endfunction

  assign hit9 = (i_req.addr == `ASQ_STEP9_ADDR);
  assign hit10 = (i_req.addr == `ASQ_STEP10_ADDR);
  assign is_step9 = (i_step_num == 4'h9);
  assign is_step10 = (i_step_num == 4'ha);
  assign step_known = is_step9 | is_step10;
  assign sel_cfg = is_step10 ? step10_r : step9_r;
  assign rdata_nxt = hit9 ? step9_r : (hit10 ? step10_r : 16'h0000);

  // positive field passes through; codes 8-15 are internal sources
  assign conv_nxt.valid = i_step_req & step_known & sel_cfg[`ASQ_EN_BIT];
  assign conv_nxt.step = i_step_num;
  assign conv_nxt.gain = gain_decode(sel_cfg[`ASQ_GAIN_HI:`ASQ_GAIN_LO]);
  assign conv_nxt.pos_sel = sel_cfg[`ASQ_POS_HI:`ASQ_POS_LO];
  assign conv_nxt.neg_sel = neg_decode(sel_cfg[`ASQ_POS_HI:`ASQ_POS_LO],
                                       sel_cfg[`ASQ_NEG_BIT]);

  // reserved bits 12:5 stay zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      step9_r <= `ASQ_STEP9_RST;
      step10_r <= `ASQ_STEP10_RST;
    end else if (i_req.wr) begin
      if (hit9) step9_r <= i_req.wdata & `ASQ_RW_MASK;
      if (hit10) step10_r <= i_req.wdata & `ASQ_RW_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
      if (i_req.rd) o_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_conv <= '0;
      o_step_skip <= 1'b0;
    end else begin
      // fields stay zero unless the step is applied
      o_conv <= conv_nxt.valid ? conv_nxt : '0;
      o_step_skip <= i_step_req & step_known & ~sel_cfg[`ASQ_EN_BIT];
    end
  end

  a_step9_reset: assert property (@(posedge i_clk)
    $rose(i_resetn) |-> step9_r == 16'h0009) else $error("step nine reset value wrong");
  a_step10_reset: assert property (@(posedge i_clk)
    $rose(i_resetn) |-> step10_r == 16'h000a) else $error("step ten reset value wrong");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (step9_r[12:5] == 8'h00) && (step10_r[12:5] == 8'h00))
    else $error("reserved bits not zero");
  a_enable_gate: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_step_req && is_step9 |=> o_conv.valid == $past(step9_r[15]))
    else $error("step enable not honoured");
  a_skip_disabled: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_step_req && step_known && !sel_cfg[15] |=> o_step_skip && !o_conv.valid)
    else $error("disabled step not skipped");
  a_gain_map: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_conv.valid |-> (o_conv.gain == ASQ_GAIN_4) == (($past(sel_cfg[14])) == 1'b1))
    else $error("gain mapping wrong");
  a_gain_two: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_step_req && step_known && sel_cfg[15] && sel_cfg[14:13] == 2'b01 |=>
    o_conv.gain == ASQ_GAIN_2)
    else $error("gain two mapping wrong");
  a_neg_auto: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_step_req && step_known && sel_cfg[15] && sel_cfg[3] |=> o_conv.neg_sel == ASQ_NEG_AUTO)
    else $error("negative select not overridden");
  a_neg_manual: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_step_req && step_known && sel_cfg[15] && !sel_cfg[3] |=>
    o_conv.neg_sel == ($past(sel_cfg[4]) ? ASQ_NEG_MUX7 : ASQ_NEG_GND))
    else $error("negative select wrong");
  a_pos_route: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_step_req && step_known && sel_cfg[15] |=> o_conv.pos_sel == $past(sel_cfg[3:0]))
    else $error("positive select wrong");
  a_read_back: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.rd && hit9 && !i_req.wr |=> o_rvalid && o_rdata == $past(step9_r))
    else $error("step nine readback wrong");

  // step apply outputs
  a_enable_ten: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_step_req && is_step10
    |=> o_conv.valid == $past(step10_r[15]))
    else $error("step ten enable not honoured");

  a_skip_exclusive: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !(o_step_skip && o_conv.valid))
    else $error("skip and apply together");

  a_unknown_step: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_step_req && !step_known
    |=> !o_step_skip && !o_conv.valid)
    else $error("unknown step answered");

  a_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_step_req
    |=> !o_step_skip && !o_conv.valid)
    else $error("step output without request");

  a_conv_idle_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_conv.valid
    |-> o_conv == '0)
    else $error("step fields not cleared");

  a_step_echo: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_conv.valid
    |-> (o_conv.step == 4'h9) || (o_conv.step == 4'ha))
    else $error("applied step number wrong");

  a_gain_one: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_step_req && step_known && sel_cfg[15] && sel_cfg[14:13] == 2'b00
    |=> o_conv.gain == ASQ_GAIN_1)
    else $error("gain one mapping wrong");

  // register access
  a_rvalid_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_req.rd
    |=> !o_rvalid)
    else $error("read valid without read");

  a_read_ten: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.rd && hit10 && !i_req.wr
    |=> o_rvalid && o_rdata == $past(step10_r))
    else $error("step ten readback wrong");

  a_read_unmapped: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.rd && !hit9 && !hit10
    |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_req.rd
    |=> $stable(o_rdata))
    else $error("read data changed without read");

  a_write_nine: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.wr && hit9
    |=> step9_r == ($past(i_req.wdata) & `ASQ_RW_MASK))
    else $error("step nine write wrong");

  a_write_ten: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_req.wr && hit10
    |=> step10_r == ($past(i_req.wdata) & `ASQ_RW_MASK))
    else $error("step ten write wrong");

  a_nine_kept: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !(i_req.wr && hit9)
    |=> $stable(step9_r))
    else $error("step nine changed without write");

  a_ten_kept: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !(i_req.wr && hit10)
    |=> $stable(step10_r))
    else $error("step ten changed without write");

  c_write_nine: cover property (@(posedge i_clk) disable iff (!i_resetn) i_req.wr && hit9);
  c_gain_four: cover property (@(posedge i_clk) disable iff (!i_resetn)
    o_conv.valid && o_conv.gain == ASQ_GAIN_4);
  c_conv_enabled: cover property (@(posedge i_clk) disable iff (!i_resetn) o_conv.valid);
  c_conv_skip: cover property (@(posedge i_clk) disable iff (!i_resetn) o_step_skip);
  c_auto_neg: cover property (@(posedge i_clk) disable iff (!i_resetn)
    o_conv.valid && o_conv.neg_sel == ASQ_NEG_AUTO);
endmodule

//--- verification/asq_step_cfg_tb.sv
// self-checking bench for the step nine and ten configuration registers
// assumes the design sees decoded one-cycle read and write strobes
`include "asq_regs.svh"
module asq_step_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asq_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_step_req = 1'b0;
  logic [3:0] i_step_num = 4'h0;
  asq_req_t i_req = '0;
  logic [15:0] o_rdata;
  logic o_rvalid;
  logic o_step_skip;
  asq_conv_t o_conv;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  asq_step_cfg asq_step_cfg_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req),
    .i_step_req(i_step_req), .i_step_num(i_step_num), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_conv(o_conv), .o_step_skip(o_step_skip));
  initial forever #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end
  task results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(string nm, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(logic [7:0] a, logic [15:0] d);
    @(posedge i_clk) i_req <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk) i_req <= '0;
  endtask
  task rd(logic [7:0] a, logic [15:0] e);
    @(posedge i_clk) i_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge i_clk) i_req <= '0;
    #1 chk("rvalid", 16'h0001, {15'h0000, o_rvalid});
    chk("rdata", e, o_rdata);
  endtask
  task step(logic [3:0] n, logic es, asq_conv_t e);
    @(posedge i_clk);
    i_step_req <= 1'b1;
    i_step_num <= n;
    @(posedge i_clk);
    i_step_req <= 1'b0;
    #1 chk("skip", {15'h0000, es}, {15'h0000, o_step_skip});
    chk("conv", {3'h0, e}, {3'h0, o_conv});
  endtask
  initial begin
    int g;
    int p;
    logic [3:0] n;
    logic [7:0] a;
    asq_gain_t ge;
    asq_neg_t ne;
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(`ASQ_STEP9_ADDR, `ASQ_STEP9_RST);
    rd(`ASQ_STEP10_ADDR, `ASQ_STEP10_RST);
    step(4'h9, 1'b1, '0);
    step(4'h5, 1'b0, '0);
    wr(`ASQ_STEP9_ADDR, 16'hffff);
    rd(`ASQ_STEP9_ADDR, `ASQ_RW_MASK);
    wr(8'h55, 16'hffff);
    rd(8'h55, 16'h0000);
    for (g = 0; g < 4; g++) begin
      for (p = 0; p < 16; p++) begin
        n = p[1] ? 4'ha : 4'h9;
        a = p[1] ? `ASQ_STEP10_ADDR : `ASQ_STEP9_ADDR;
        ge = (g == 0) ? ASQ_GAIN_1 : (g == 1) ? ASQ_GAIN_2 : ASQ_GAIN_4;
        ne = p[3] ? ASQ_NEG_AUTO : (p[0] ? ASQ_NEG_MUX7 : ASQ_NEG_GND);
        wr(a, {1'b1, g[1:0], 8'h00, p[0], p[3:0]});
        step(n, 1'b0, '{1'b1, n, ge, p[3:0], ne});
      end
    end
    wr(`ASQ_STEP10_ADDR, 16'h6003);
    step(4'ha, 1'b1, '0);
    results();
  end
endmodule
